// ### rtl/adcr_regs.v
// control, configuration and part number registers of the accelerometer
`timescale 1ns/10ps
`default_nettype none
`include "adcr_defs.vh"

module adcr_regs #(
    parameter [7:0] PART_NUMBER = 8'h5a // arbitrary value, no meaning
) (
    // clock and reset
    input wire clk_sys_i,
    input wire rst_n_i,
    // register command port from the serial front end
    input wire cmd_valid_i,
    input wire cmd_write_i,
    input wire [7:0] cmd_addr_i,
    input wire [7:0] cmd_wdata_i,
    // register response
    output reg rsp_valid_o,
    output reg [7:0] rsp_data_o,
    output reg rsp_invalid_o,
    // stored self test bits of the axis registers
    input wire self_test_x_enable_i,
    input wire self_test_y_enable_i,
    // effective controls to the signal path
    output reg [1:0] offset_cancel_phase_o,
    output reg phase_hold_o,
    output reg raw_data_select_o,
    output reg unsigned_format_select_o,
    output reg offset_monitor_active_o,
    output reg [2:0] arm_config_o,
    output reg crc_check_enable_o,
    output reg self_test_x_active_o,
    output reg self_test_y_active_o,
    output reg init_done_lock_o,
    output reg digital_reset_o
);

    // reset sequence states
    localparam [1:0] SEQ_IDLE = 2'h0;
    localparam [1:0] SEQ_GOT_FIRST = 2'h1;
    localparam [1:0] SEQ_GOT_SECOND = 2'h2;

    // stored state
    reg [5:0] control_low;
    reg [7:0] config_reg;
    reg [1:0] seq_state;
    reg soft_reset;

    // next values of the stored state and the response
    reg [5:0] next_control_low;
    reg [7:0] next_config;
    reg [1:0] next_seq_state;
    reg next_soft_reset;
    reg [7:0] next_rsp_data;
    reg next_rsp_invalid;

    // decoded command
    reg [1:0] key;
    reg lock;
    reg hit_part;
    reg hit_control;
    reg hit_config;
    reg ctl_wr;
    reg cfg_wr;

    // effective controls ahead of their output flops
    reg [1:0] next_phase;
    reg next_phase_hold;
    reg next_raw_select;
    reg next_unsigned_select;
    reg next_monitor_active;
    reg [2:0] next_arm_config;
    reg next_crc_enable;
    reg next_self_test_x;
    reg next_self_test_y;
    reg next_lock;
    reg next_digital_reset;

    // address decode of the current command
    always @* begin
        key = cmd_wdata_i[`ADCR_CTL_KEY_HIGH:`ADCR_CTL_KEY_LOW];
        lock = config_reg[`ADCR_CFG_LOCK];
        hit_part = 1'b0;
        hit_control = 1'b0;
        hit_config = 1'b0;
        if (cmd_addr_i == `ADCR_ADDR_CONTROL) begin
            hit_control = 1'b1;
        end else if (cmd_addr_i == `ADCR_ADDR_CONFIG) begin
            hit_config = 1'b1;
        end else if (cmd_addr_i == `ADCR_ADDR_PART_NUMBER) begin
            hit_part = 1'b1;
        end
        ctl_wr = cmd_valid_i && cmd_write_i && hit_control;
        cfg_wr = cmd_valid_i && cmd_write_i && hit_config;
    end

    // low control bits only change before the lock; key bits are never stored
    always @* begin
        next_control_low = control_low;
        if (ctl_wr && !lock) begin
            next_control_low[2:0] = cmd_wdata_i[2:0];
            next_control_low[`ADCR_CTL_PHASE_EN] = cmd_wdata_i[`ADCR_CTL_PHASE_EN];
            // the enable carried in the same write decides whether the phase loads
            if (cmd_wdata_i[`ADCR_CTL_PHASE_EN]) begin
                next_control_low[`ADCR_CTL_PHASE_HI:`ADCR_CTL_PHASE_LO] =
                    cmd_wdata_i[`ADCR_CTL_PHASE_HI:`ADCR_CTL_PHASE_LO];
            end
        end
    end

    // configuration is frozen once the lock is set; the lock itself only clears by reset
    always @* begin
        next_config = config_reg;
        if (cfg_wr && !lock) begin
            next_config = cmd_wdata_i;
            next_config[`ADCR_CFG_RESERVED] = 1'b0;
        end
    end

    // any command other than the expected key write breaks the sequence
    always @* begin
        next_seq_state = seq_state;
        next_soft_reset = 1'b0;
        if (cmd_valid_i) begin
            next_seq_state = SEQ_IDLE;
            case (seq_state)
                SEQ_IDLE: begin
                    if (ctl_wr && key == `ADCR_KEY_FIRST) begin
                        next_seq_state = SEQ_GOT_FIRST;
                    end
                end
                SEQ_GOT_FIRST: begin
                    if (ctl_wr && key == `ADCR_KEY_FIRST) begin
                        next_seq_state = SEQ_GOT_FIRST;
                    end else if (ctl_wr && key == `ADCR_KEY_SECOND) begin
                        next_seq_state = SEQ_GOT_SECOND;
                    end
                end
                SEQ_GOT_SECOND: begin
                    if (ctl_wr && key == `ADCR_KEY_FIRST) begin
                        next_seq_state = SEQ_GOT_FIRST;
                    end else if (ctl_wr && key == `ADCR_KEY_THIRD) begin
                        next_soft_reset = 1'b1;
                    end
                end
                default: begin
                    if (ctl_wr && key == `ADCR_KEY_FIRST) begin
                        next_seq_state = SEQ_GOT_FIRST;
                    end
                end
            endcase
        end
    end

    // responses: key bits always read as zero, unmapped addresses flagged
    always @* begin
        next_rsp_data = 8'h00;
        next_rsp_invalid = 1'b0;
        if (cmd_valid_i) begin
            if (hit_control) begin
                next_rsp_data = {2'b00, next_control_low};
            end else if (hit_config) begin
                next_rsp_data = next_config;
            end else if (hit_part) begin
                next_rsp_data = PART_NUMBER;
            end else begin
                next_rsp_invalid = 1'b1;
            end
        end
    end

    // the lock overrides phase and self test without touching the stored bits
    always @* begin
        if (lock) begin
            next_phase = `ADCR_PHASE_NORMAL;
        end else begin
            next_phase = control_low[`ADCR_CTL_PHASE_HI:`ADCR_CTL_PHASE_LO];
        end
        next_phase_hold = control_low[`ADCR_CTL_PHASE_EN] && !lock;
        next_raw_select = config_reg[`ADCR_CFG_RAW_SEL];
        next_unsigned_select = config_reg[`ADCR_CFG_UNSIGNED];
        // offset-cancelled data never runs without its monitor
        next_monitor_active = config_reg[`ADCR_CFG_MON_EN] ||
            !config_reg[`ADCR_CFG_RAW_SEL];
        next_arm_config = config_reg[`ADCR_CFG_ARM_HI:`ADCR_CFG_ARM_LO];
        next_crc_enable = lock;
        next_self_test_x = self_test_x_enable_i && !lock;
        next_self_test_y = self_test_y_enable_i && !lock;
        next_lock = lock;
        next_digital_reset = soft_reset;
    end

    // the cycle after the third key write wipes the bank; a command in that cycle is lost
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            control_low <= `ADCR_CONTROL_LOW_RESET;
        end else if (soft_reset) begin
            control_low <= `ADCR_CONTROL_LOW_RESET;
        end else begin
            control_low <= next_control_low;
        end
    end

    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            config_reg <= `ADCR_CONFIG_RESET;
        end else if (soft_reset) begin
            config_reg <= `ADCR_CONFIG_RESET;
        end else begin
            config_reg <= next_config;
        end
    end

    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            seq_state <= SEQ_IDLE;
        end else if (soft_reset) begin
            seq_state <= SEQ_IDLE;
        end else begin
            seq_state <= next_seq_state;
        end
    end

    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            soft_reset <= 1'b0;
        end else if (soft_reset) begin
            soft_reset <= 1'b0;
        end else begin
            soft_reset <= next_soft_reset;
        end
    end

    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rsp_valid_o <= 1'b0;
        end else if (soft_reset) begin
            rsp_valid_o <= 1'b0;
        end else begin
            rsp_valid_o <= cmd_valid_i;
        end
    end

    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rsp_data_o <= 8'h00;
        end else if (soft_reset) begin
            rsp_data_o <= 8'h00;
        end else begin
            rsp_data_o <= next_rsp_data;
        end
    end

    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rsp_invalid_o <= 1'b0;
        end else if (soft_reset) begin
            rsp_invalid_o <= 1'b0;
        end else begin
            rsp_invalid_o <= next_rsp_invalid;
        end
    end

    // every effective control leaves its own flip-flop, one cycle after the registers
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            offset_cancel_phase_o <= `ADCR_PHASE_NORMAL;
        end else begin
            offset_cancel_phase_o <= next_phase;
        end
    end

    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase_hold_o <= 1'b0;
        end else begin
            phase_hold_o <= next_phase_hold;
        end
    end

    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            raw_data_select_o <= 1'b0;
        end else begin
            raw_data_select_o <= next_raw_select;
        end
    end

    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            unsigned_format_select_o <= 1'b0;
        end else begin
            unsigned_format_select_o <= next_unsigned_select;
        end
    end

    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            offset_monitor_active_o <= `ADCR_MONITOR_RESET;
        end else begin
            offset_monitor_active_o <= next_monitor_active;
        end
    end

    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            arm_config_o <= 3'h0;
        end else begin
            arm_config_o <= next_arm_config;
        end
    end

    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            crc_check_enable_o <= 1'b0;
        end else begin
            crc_check_enable_o <= next_crc_enable;
        end
    end

    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            self_test_x_active_o <= 1'b0;
        end else begin
            self_test_x_active_o <= next_self_test_x;
        end
    end

    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            self_test_y_active_o <= 1'b0;
        end else begin
            self_test_y_active_o <= next_self_test_y;
        end
    end

    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            init_done_lock_o <= 1'b0;
        end else begin
            init_done_lock_o <= next_lock;
        end
    end

    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            digital_reset_o <= 1'b0;
        end else begin
            digital_reset_o <= next_digital_reset;
        end
    end

endmodule
`default_nettype wire

// ### rtl/adcr_defs.vh
// constants of the accelerometer control register bank
`ifndef ADCR_DEFS_VH
`define ADCR_DEFS_VH

// register offsets
`define ADCR_ADDR_PART_NUMBER 8'h08
`define ADCR_ADDR_CONTROL 8'h0a
`define ADCR_ADDR_CONFIG 8'h0b

// reset values
`define ADCR_CONTROL_RESET 8'h00
`define ADCR_CONFIG_RESET 8'h00
`define ADCR_CONTROL_LOW_RESET 6'h00
`define ADCR_MONITOR_RESET 1'b1

// control field positions
`define ADCR_CTL_KEY_HIGH 7
`define ADCR_CTL_KEY_LOW 6
`define ADCR_CTL_PHASE_HI 5
`define ADCR_CTL_PHASE_LO 4
`define ADCR_CTL_PHASE_EN 3

// configuration field positions
`define ADCR_CFG_RAW_SEL 7
`define ADCR_CFG_RESERVED 6
`define ADCR_CFG_LOCK 5
`define ADCR_CFG_UNSIGNED 4
`define ADCR_CFG_MON_EN 3
`define ADCR_CFG_ARM_HI 2
`define ADCR_CFG_ARM_LO 0

// reset key sequence and phase codes
`define ADCR_KEY_FIRST 2'h0
`define ADCR_KEY_SECOND 2'h3
`define ADCR_KEY_THIRD 2'h1
`define ADCR_PHASE_NORMAL 2'h3

`endif

// ### dv/adcr_regs_assertions.sv
// port assertions for the control register bank
`timescale 1ns/10ps
`default_nettype none
module adcr_regs_checker #(parameter logic [7:0] PART_NUMBER = 8'h5a) (
    // watched ports
    input wire logic clk_sys_i, rst_n_i, cmd_valid_i, rsp_valid_o, rsp_invalid_o,
    input wire logic phase_hold_o, raw_data_select_o, offset_monitor_active_o,
    input wire logic crc_check_enable_o, self_test_x_active_o, init_done_lock_o,
    input wire logic digital_reset_o,
    input wire logic [7:0] cmd_addr_i, rsp_data_o,
    input wire logic [1:0] offset_cancel_phase_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_ask(a);
        cmd_valid_i && cmd_addr_i == a;
    endsequence
    sequence s_pulse;
        digital_reset_o ##1 !digital_reset_o && !init_done_lock_o;
    endsequence
    // a command in the soft reset cycle gets no answer, hence the !rsp_valid_o escape
    chk_rsp_has_cause: assert property (rsp_valid_o |-> $past(cmd_valid_i))
        else $error("response without command");
    chk_part_code_read: assert property (s_ask(8'h08) |=>
        !rsp_valid_o || rsp_data_o == PART_NUMBER) else $error("part code wrong");
    chk_ctl_key_zero: assert property (s_ask(8'h0a) |=>
        !rsp_valid_o || rsp_data_o[7:6] == 2'h0) else $error("key bits not zero");
    chk_unmapped_flag: assert property (cmd_valid_i &&
        !(cmd_addr_i inside {8'h08, 8'h0a, 8'h0b}) |=> !rsp_valid_o ||
        (rsp_invalid_o && rsp_data_o == 8'h00)) else $error("unmapped answer wrong");
    chk_crc_with_lock: assert property (crc_check_enable_o == init_done_lock_o)
        else $error("crc enable differs from lock");
    chk_lock_forces_normal: assert property (init_done_lock_o && $past(init_done_lock_o) |->
        offset_cancel_phase_o == 2'h3 && !phase_hold_o) else $error("phase not normal");
    chk_lock_stops_selftest: assert property (init_done_lock_o && $past(init_done_lock_o) |->
        !self_test_x_active_o) else $error("self test active under lock");
    chk_monitor_forced_on: assert property (!raw_data_select_o &&
        $stable(raw_data_select_o) |-> offset_monitor_active_o) else $error("monitor off");
    chk_lock_clear_reset: assert property ($fell(init_done_lock_o) |-> $past(digital_reset_o))
        else $error("lock cleared without reset");
    chk_reset_pulse: assert property ($rose(digital_reset_o) |-> s_pulse)
        else $error("reset pulse wrong");
endmodule
bind adcr_regs adcr_regs_checker #(.PART_NUMBER(PART_NUMBER)) i_chk (.clk_sys_i, .rst_n_i,
    .cmd_valid_i, .rsp_valid_o, .rsp_invalid_o, .phase_hold_o, .raw_data_select_o,
    .offset_monitor_active_o, .crc_check_enable_o, .self_test_x_active_o, .init_done_lock_o,
    .digital_reset_o, .cmd_addr_i, .rsp_data_o, .offset_cancel_phase_o);
`default_nettype wire

// ### dv/adcr_host_model.sv
// host side model issuing register commands
`timescale 1ns/10ps
`default_nettype none
module adcr_host_model (
    // clock and answer
    input wire logic clk_sys_i,
    input wire logic rsp_valid_i,
    input wire logic rsp_invalid_i,
    input wire logic [7:0] rsp_data_i,
    // command
    output var logic cmd_valid_o,
    output var logic cmd_write_o,
    output var logic [7:0] cmd_addr_o,
    output var logic [7:0] cmd_wdata_o
);
    initial begin
        {cmd_valid_o, cmd_write_o, cmd_addr_o, cmd_wdata_o} = 18'h0;
    end
    // one command; the answer is taken one cycle later, all ones when none came
    task automatic xfer(input logic wr, input logic [7:0] a, d, output logic [12:0] r);
        @(negedge clk_sys_i);
        cmd_valid_o = 1'b1;
        cmd_write_o = wr;
        cmd_addr_o = a;
        cmd_wdata_o = d & ((a == 8'h0a) ? 8'hf8 : ((a == 8'h0b) ? 8'hbf : 8'hff));
        @(negedge clk_sys_i);
        cmd_valid_o = 1'b0;
        cmd_addr_o = ~cmd_addr_o;
        cmd_wdata_o = ~cmd_wdata_o;
        r = rsp_valid_i ? {4'h0, rsp_invalid_i, rsp_data_i} : 13'h1fff;
    endtask
    // key writes sent with nothing in between, else the device drops the sequence
    task automatic soft_reset(output logic [12:0] r);
        xfer(1'b1, 8'h0a, 8'h00, r);
        xfer(1'b1, 8'h0a, 8'hc0, r);
        xfer(1'b1, 8'h0a, 8'h40, r);
    endtask
endmodule
`default_nettype wire

// ### dv/accel_device_control_regs_bench.sv
// self-checking bench of the accelerometer control register bank
`timescale 1ns/10ps
`default_nettype none
module accel_device_control_regs_bench;
    localparam logic [7:0] PART_CODE = 8'h3c; // arbitrary value
    logic clk_sys_i = 1'b0, rst_n_i = 1'b0, self_test_x_enable_i = 1'b0, rst_seen = 1'b0;
    wire logic cmd_valid_i, cmd_write_i, rsp_valid_o, rsp_invalid_o, phase_hold_o, digital_reset_o;
    wire logic raw_data_select_o, unsigned_format_select_o, offset_monitor_active_o;
    wire logic crc_check_enable_o, init_done_lock_o, self_test_x_active_o, self_test_y_active_o;
    wire logic [7:0] cmd_addr_i, cmd_wdata_i, rsp_data_o;
    wire logic [1:0] offset_cancel_phase_o;
    wire logic [2:0] arm_config_o;
    wire logic [12:0] eff_seen = {init_done_lock_o, crc_check_enable_o, phase_hold_o,
        offset_cancel_phase_o, raw_data_select_o, unsigned_format_select_o,
        offset_monitor_active_o, self_test_x_active_o, self_test_y_active_o, arm_config_o};
    logic [12:0] r;
    logic [7:0] cfg_tab [4] = '{8'h93, 8'h80, 8'h88, 8'h14};
    int error_cnt = 0, check_count = 0;
    always #50 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) if (digital_reset_o) rst_seen <= 1'b1;
    adcr_regs #(.PART_NUMBER(PART_CODE)) i_dut (.clk_sys_i, .rst_n_i, .cmd_valid_i, .cmd_write_i,
        .cmd_addr_i, .cmd_wdata_i, .rsp_valid_o, .rsp_data_o, .rsp_invalid_o,
        .self_test_x_enable_i, .self_test_y_enable_i(self_test_x_enable_i),
        .offset_cancel_phase_o, .phase_hold_o, .raw_data_select_o, .unsigned_format_select_o,
        .offset_monitor_active_o, .arm_config_o, .crc_check_enable_o, .self_test_x_active_o,
        .self_test_y_active_o, .init_done_lock_o, .digital_reset_o);
    adcr_host_model h (.clk_sys_i, .rsp_valid_i(rsp_valid_o), .rsp_invalid_i(rsp_invalid_o),
        .rsp_data_i(rsp_data_o), .cmd_valid_o(cmd_valid_i), .cmd_write_o(cmd_write_i),
        .cmd_addr_o(cmd_addr_i), .cmd_wdata_o(cmd_wdata_i));
    function automatic logic [12:0] eff(input logic lk, hd, input logic [1:0] ph,
                                        input logic [7:0] c);
        return {lk, lk, hd, ph, c[7], c[4], c[3] | ~c[7], {2{self_test_x_enable_i & ~lk}}, c[2:0]};
    endfunction
    task automatic chk(input string what, input logic [12:0] exp, got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge clk_sys_i);
        error_cnt++;
        finish_test;
    end
    initial begin
        idle(5);
        rst_n_i = 1'b1;
        h.xfer(1, 8'h08, 8'hff, r); chk("part code", {5'h0, PART_CODE}, r);
        h.xfer(0, 8'h0a, 8'h00, r); chk("control reset", 13'h000, r);
        h.xfer(0, 8'h09, 8'h00, r); chk("unmapped", 13'h100, r);
        chk("reset outputs", eff(0, 0, 2'h0, 8'h00), eff_seen);
        $display("test map done");
        for (int p = 0; p < 4; p++) begin
            h.xfer(1, 8'h0a, {2'h3, p[1:0], 4'h8}, r); chk("phase write", {7'h0, p[1:0], 4'h8}, r);
            idle(2); chk("phase held", eff(0, 1, p[1:0], 8'h00), eff_seen);
        end
        h.xfer(1, 8'h0a, 8'h00, r); chk("phase ignored", 13'h030, r);
        idle(2); chk("phase kept", eff(0, 0, 2'h3, 8'h00), eff_seen);
        foreach (cfg_tab[i]) begin
            h.xfer(1, 8'h0b, cfg_tab[i], r); chk("config write", {5'h0, cfg_tab[i]}, r);
            idle(2); chk("config out", eff(0, 0, 2'h3, cfg_tab[i]), eff_seen);
        end
        $display("test phase and config done");
        // a read in the middle must spoil the key sequence
        h.xfer(1, 8'h0a, 8'h00, r);
        h.xfer(1, 8'h0a, 8'hc0, r); chk("key bits", 13'h030, r);
        h.xfer(0, 8'h0a, 8'h00, r);
        h.xfer(1, 8'h0a, 8'h40, r);
        idle(4); chk("broken key", 13'h0, {12'h0, rst_seen});
        h.xfer(1, 8'h0a, 8'h18, r);
        self_test_x_enable_i = 1'b1;
        h.xfer(1, 8'h0b, 8'hb3, r); chk("lock write", 13'h0b3, r);
        idle(2); chk("locked out", eff(1, 0, 2'h3, 8'hb3), eff_seen);
        h.xfer(1, 8'h0b, 8'h00, r); chk("config locked", 13'h0b3, r);
        h.xfer(1, 8'h0a, 8'h2c, r); chk("control locked", 13'h018, r);
        h.soft_reset(r);
        idle(4); chk("reset pulse", 13'h1, {12'h0, rst_seen});
        h.xfer(0, 8'h0b, 8'h00, r); chk("config cleared", 13'h000, r);
        h.xfer(0, 8'h0a, 8'h00, r); chk("control cleared", 13'h000, r);
        chk("outputs cleared", eff(0, 0, 2'h0, 8'h00), eff_seen);
        $display("test lock and reset done");
        finish_test;
    end
endmodule
`default_nettype wire
